// ==== include/spis_pkg.sv ====
// How it works
// - Word into empty receive FIFO sets bit 0.
// - Transmit FIFO drained by shifting sets bit 1.
// - Receive level rising above threshold sets bit 2.
// - Transmit level dropping below threshold sets bit 3.
// - Word arriving to full receive FIFO discarded, bit 4.
// - Write to full transmit FIFO sets bit 5.
// - Read of empty receive FIFO sets bit 6.
// - Empty transmit FIFO sends 0x00, sets bit 7.
// - No further receive within timeout period after a received word sets bit 8.
package spis_pkg;
  localparam int          EVENT_COUNT      = 9;
  localparam int          EV_RX_FIRST      = 0;
  localparam int          EV_TX_DRAINED    = 1;
  localparam int          EV_RX_RISE       = 2;
  localparam int          EV_TX_DROP       = 3;
  localparam int          EV_RX_OVERFLOW   = 4;
  localparam int          EV_TX_OVERFLOW   = 5;
  localparam int          EV_RX_UNDERFLOW  = 6;
  localparam int          EV_TX_UNDERFLOW  = 7;
  localparam int          EV_RX_TIMEOUT    = 8;
  localparam logic [11:0] ADDR_STATUS      = 12'h000;
  localparam logic [11:0] ADDR_ENABLE      = 12'h004;
  localparam logic [11:0] ADDR_RX_THRESH   = 12'h008;
  localparam logic [11:0] ADDR_TX_THRESH   = 12'h00c;
  localparam logic [11:0] ADDR_TIMEOUT     = 12'h010;
  localparam logic [11:0] ADDR_RX_DATA     = 12'h014;
  localparam logic [11:0] ADDR_TX_DATA     = 12'h018;
  localparam logic [11:0] ADDR_LEVELS      = 12'h01c;
  localparam logic [7:0]  UNDERRUN_BYTE    = 8'h00;
  localparam logic [31:0] TIMEOUT_RESET    = 32'h0000_0100;
  localparam int          LEVEL_TX_LSB     = 16;
  typedef enum logic [1:0] {
    XFER_IDLE  = 2'b00,
    XFER_SHIFT = 2'b01
  } xfer_state_t;
endpackage

// ==== logic/byte_fifo.sv ====
`timescale 1ns/10ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             ce,
  // Write side
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wr_data,
  // Read side
  input  wire logic             rd_en,
  output logic      [WIDTH-1:0] rd_data,
  // Occupancy
  output logic      [AW:0]      level
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wptr;
  logic [AW-1:0]    rptr;
  wire              do_wr = wr_en && (level != (AW+1)'(DEPTH));
  wire              do_rd = rd_en && (level != '0);

  always_ff @(posedge pclk)
    if (ce && do_wr)
      mem[wptr] <= wr_data;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      wptr    <= '0;
      rptr    <= '0;
      level   <= '0;
      rd_data <= '0;
    end
    else if (ce)
    begin
      if (do_wr)
        wptr <= (wptr == AW'(DEPTH - 1)) ? '0 : wptr + 1'b1;
      if (do_rd)
      begin
        rd_data <= mem[rptr];
        rptr    <= (rptr == AW'(DEPTH - 1)) ? '0 : rptr + 1'b1;
      end
      level <= level + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
endmodule

// ==== logic/spi_slave_fifo_event_logic.sv ====
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/10ps
module spi_slave_fifo_event_logic #(
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  // System clock, reset and enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // SPI pins, mode 0, master drives clock and select
  input  wire logic        spi_sclk,
  input  wire logic        spi_csn,
  input  wire logic        spi_mosi,
  output logic             spi_miso,
  output logic             spi_miso_oe,
  // Interrupt
  output logic             irq
);
  localparam int EC = spis_pkg::EVENT_COUNT;

  // Pin synchronisers.
  logic [1:0] sclk_s, csn_s, mosi_s;
  logic       sclk_d;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      sclk_s <= '0;
      csn_s  <= 2'b11;
      mosi_s <= '0;
      sclk_d <= 1'b0;
    end
    else if (ce)
    begin
      sclk_s <= {sclk_s[0], spi_sclk};
      csn_s  <= {csn_s[0], spi_csn};
      mosi_s <= {mosi_s[0], spi_mosi};
      sclk_d <= sclk_s[1];
    end
  wire sel      = !csn_s[1];
  wire sclk_ris = sel && sclk_s[1] && !sclk_d;
  wire sclk_fal = sel && !sclk_s[1] && sclk_d;

  // APB decode.
  wire        apb_acc = psel && penable;
  wire        apb_wr  = apb_acc && pwrite;
  wire        apb_rd  = apb_acc && !pwrite;
  wire        hit_st  = paddr == spis_pkg::ADDR_STATUS;
  wire        hit_en  = paddr == spis_pkg::ADDR_ENABLE;
  wire        hit_rth = paddr == spis_pkg::ADDR_RX_THRESH;
  wire        hit_tth = paddr == spis_pkg::ADDR_TX_THRESH;
  wire        hit_to  = paddr == spis_pkg::ADDR_TIMEOUT;
  wire        hit_rx  = paddr == spis_pkg::ADDR_RX_DATA;
  wire        hit_tx  = paddr == spis_pkg::ADDR_TX_DATA;
  wire        hit_lv  = paddr == spis_pkg::ADDR_LEVELS;
  wire        mapped  = hit_st | hit_en | hit_rth | hit_tth | hit_to | hit_rx | hit_tx | hit_lv;

  // Configuration and status.
  logic [EC-1:0] status;
  logic [EC-1:0] enable;
  logic [AW:0]   rx_thresh;
  logic [AW:0]   tx_thresh;
  logic [31:0]   timeout;
  logic [EC-1:0] ev;

  // FIFOs.
  logic [AW:0] rx_level, tx_level;
  logic [7:0]  rx_rdata, tx_rdata;
  logic        rx_push;
  logic [7:0]  rx_word;
  logic        tx_pop;
  logic        rx_wait;
  wire         rx_full  = rx_level == (AW+1)'(DEPTH);
  wire         tx_full  = tx_level == (AW+1)'(DEPTH);
  wire         rx_empty = rx_level == '0;
  wire         tx_empty = tx_level == '0;
  wire         rx_pop   = apb_rd && hit_rx && !rx_empty && !rx_wait;
  wire         tx_push  = apb_wr && hit_tx && !tx_full;
  wire         rx_wr    = rx_push && !rx_full;

  byte_fifo #(.WIDTH(8), .DEPTH(DEPTH), .AW(AW)) rx_fifo (
    .pclk(pclk), .presetn(presetn), .ce(ce),
    .wr_en(rx_wr), .wr_data(rx_word),
    .rd_en(rx_pop), .rd_data(rx_rdata), .level(rx_level)
  );
  byte_fifo #(.WIDTH(8), .DEPTH(DEPTH), .AW(AW)) tx_fifo (
    .pclk(pclk), .presetn(presetn), .ce(ce),
    .wr_en(tx_push), .wr_data(pwdata[7:0]),
    .rd_en(tx_pop), .rd_data(tx_rdata), .level(tx_level)
  );

  // Serial shifter: bytes are MSB first, sampled on rising, shifted on falling.
  spis_pkg::xfer_state_t state, next_state;
  logic [2:0] bit_cnt;
  logic [7:0] rx_sh, tx_sh;
  logic       load_pend;
  logic       tx_under;
  logic       tx_from_fifo;
  logic       loaded;
  logic       under_pend;
  wire        byte_start = sel && state == spis_pkg::XFER_IDLE;
  wire        byte_done  = sclk_ris && bit_cnt == 3'h7;
  wire        byte_begin = sclk_ris && bit_cnt == 3'h0;
  // A byte prefetched at the end of a frame is kept for the next frame, unless it is a filler.
  wire        byte_load  = (byte_start && (!loaded || under_pend)) || byte_done;
  always_comb
  begin
    next_state = state;
    case (state)
      spis_pkg::XFER_IDLE:  next_state = sel ? spis_pkg::XFER_SHIFT : spis_pkg::XFER_IDLE;
      spis_pkg::XFER_SHIFT: next_state = !sel ? spis_pkg::XFER_IDLE : state;
      default:              next_state = spis_pkg::XFER_IDLE;
    endcase
  end
  assign tx_pop = byte_load && !tx_empty;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      state        <= spis_pkg::XFER_IDLE;
      bit_cnt      <= '0;
      rx_sh        <= '0;
      tx_sh        <= spis_pkg::UNDERRUN_BYTE;
      load_pend    <= 1'b0;
      tx_under     <= 1'b0;
      tx_from_fifo <= 1'b0;
      loaded       <= 1'b0;
      under_pend   <= 1'b0;
      rx_push      <= 1'b0;
      rx_word      <= '0;
    end
    else if (ce)
    begin
      state     <= next_state;
      rx_push   <= byte_done;
      tx_under  <= 1'b0;
      load_pend <= tx_pop;
      if (!sel)
        bit_cnt <= '0;
      else if (sclk_ris)
      begin
        bit_cnt <= bit_cnt + 3'h1;
        rx_sh   <= {rx_sh[6:0], mosi_s[1]};
      end
      if (byte_done)
        rx_word <= {rx_sh[6:0], mosi_s[1]};
      // The underrun is only reported once the master really clocks the filler byte.
      if (byte_begin)
      begin
        loaded   <= 1'b0;
        tx_under <= under_pend;
      end
      if (byte_load)
      begin
        tx_from_fifo <= !tx_empty;
        loaded       <= 1'b1;
        under_pend   <= tx_empty;
        if (tx_empty)
          tx_sh <= spis_pkg::UNDERRUN_BYTE;
      end
      else if (load_pend)
        tx_sh <= tx_rdata;
      else if (sclk_fal && bit_cnt != 3'h0)
        tx_sh <= {tx_sh[6:0], 1'b0};
    end

  assign spi_miso    = tx_sh[7];
  assign spi_miso_oe = sel;

  // Level crossings use the level one cycle back.
  logic [AW:0] rx_level_d, tx_level_d;
  logic        drain_pend;
  logic [31:0] idle_cnt;
  logic        idle_armed;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      rx_level_d <= '0;
      tx_level_d <= '0;
      drain_pend <= 1'b0;
      idle_cnt   <= '0;
      idle_armed <= 1'b0;
    end
    else if (ce)
    begin
      rx_level_d <= rx_level;
      tx_level_d <= tx_level;
      if (byte_begin)
        drain_pend <= tx_from_fifo;
      if (rx_push)
      begin
        idle_cnt   <= '0;
        idle_armed <= 1'b1;
      end
      else if (idle_armed && idle_cnt >= timeout)
        idle_armed <= 1'b0;
      else if (idle_armed)
        idle_cnt <= idle_cnt + 32'h1;
    end

  // Event detection.
  always_comb
  begin
    ev                            = '0;
    ev[spis_pkg::EV_RX_FIRST]     = rx_wr && rx_empty;
    ev[spis_pkg::EV_TX_DRAINED]   = drain_pend && byte_done && tx_empty;
    ev[spis_pkg::EV_RX_RISE]      = rx_level > rx_thresh && rx_level_d <= rx_thresh;
    ev[spis_pkg::EV_TX_DROP]      = tx_level < tx_thresh && tx_level_d >= tx_thresh;
    ev[spis_pkg::EV_RX_OVERFLOW]  = rx_push && rx_full;
    ev[spis_pkg::EV_TX_OVERFLOW]  = apb_wr && hit_tx && tx_full;
    ev[spis_pkg::EV_RX_UNDERFLOW] = apb_rd && hit_rx && rx_empty && !rx_wait;
    ev[spis_pkg::EV_TX_UNDERFLOW] = tx_under;
    ev[spis_pkg::EV_RX_TIMEOUT]   = idle_armed && !rx_push && idle_cnt >= timeout;
  end

  // Registers: a set in the same cycle as a clear wins.
  wire [EC-1:0] st_clr = (apb_wr && hit_st) ? pwdata[EC-1:0] : '0;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      status    <= '0;
      enable    <= '0;
      rx_thresh <= '0;
      tx_thresh <= '0;
      timeout   <= spis_pkg::TIMEOUT_RESET;
    end
    else if (ce)
    begin
      status <= (status & ~st_clr) | ev;
      if (apb_wr && hit_en)
        enable <= pwdata[EC-1:0];
      if (apb_wr && hit_rth)
        rx_thresh <= pwdata[AW:0];
      if (apb_wr && hit_tth)
        tx_thresh <= pwdata[AW:0];
      if (apb_wr && hit_to)
        timeout <= pwdata;
    end

  // Read data: the receive data register needs one extra cycle for the memory read.
  wire  rx_slot = apb_rd && hit_rx && !rx_empty;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      rx_wait <= 1'b0;
    else if (ce)
      rx_wait <= rx_slot && !rx_wait;

  wire [31:0] rd_mux =
    hit_st  ? {{(32-EC){1'b0}}, status} :
    hit_en  ? {{(32-EC){1'b0}}, enable} :
    hit_rth ? {{(31-AW){1'b0}}, rx_thresh} :
    hit_tth ? {{(31-AW){1'b0}}, tx_thresh} :
    hit_to  ? timeout :
    hit_lv  ? ({{(31-AW){1'b0}}, tx_level} << spis_pkg::LEVEL_TX_LSB) | {{(31-AW){1'b0}}, rx_level} :
    32'h0000_0000;

  assign pready  = !(hit_rx && apb_rd && !rx_wait && !rx_empty);
  assign pslverr = apb_acc && !mapped;
  assign prdata  = (hit_rx && rx_wait) ? {24'h00_0000, rx_rdata} : rd_mux;
  assign irq     = |(status & enable);
endmodule

// ==== verification/spi_master_model.sv ====
`timescale 1ns/10ps
module spi_master_model (
  // Link pins
  output logic      spi_sclk,
  output logic      spi_csn,
  output logic      spi_mosi,
  input  wire logic spi_miso
);
  initial
  begin
    spi_sclk = 1'b0;
    spi_csn  = 1'b1;
    spi_mosi = 1'b1;
  end
  // One mode 0 frame; the 1 ns offset keeps pin changes off the block's clock edges.
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    #1 spi_csn = 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      spi_mosi = tx[i];
      #40 spi_sclk = 1'b1;
      rx[i] = spi_miso;
      #40 spi_sclk = 1'b0;
    end
    #40 spi_csn = 1'b1;
    spi_mosi = 1'b1;
    #40;
  endtask
endmodule

// ==== verification/spi_slave_fifo_event_logic_test.sv ====
`timescale 1ns/10ps
module spi_slave_fifo_event_logic_test;
  localparam logic [11:0] STA = spis_pkg::ADDR_STATUS;
  localparam logic [11:0] RXD = spis_pkg::ADDR_RX_DATA;
  localparam logic [11:0] TXD = spis_pkg::ADDR_TX_DATA;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        spi_sclk;
  logic        spi_csn;
  logic        spi_mosi;
  logic        spi_miso;
  logic        irq;
  logic [31:0] rd;
  logic        err;
  logic [7:0]  mb;
  int          mismatches = 0;
  int          tests_run = 0;
  spi_slave_fifo_event_logic #(.DEPTH(4), .AW(2)) spi_slave_fifo_event_logic_i (
    .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .spi_sclk(spi_sclk), .spi_csn(spi_csn), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .spi_miso_oe(), .irq(irq));
  spi_master_model spi_master_model_i (
    .spi_sclk(spi_sclk), .spi_csn(spi_csn), .spi_mosi(spi_mosi), .spi_miso(spi_miso));
  always #2 pclk = ~pclk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic expect_reg(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rd, e);
  endtask
  task automatic irq_is(input logic e);
    @(negedge pclk);
    check({31'h0, irq}, {31'h0, e});
  endtask
  task automatic print_verdict;
    if (mismatches == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic t_regs;
    expect_reg(spis_pkg::ADDR_TIMEOUT, spis_pkg::TIMEOUT_RESET);
    expect_reg(STA, 32'h0);
    expect_reg(12'h020, 32'h0);
    check({31'h0, err}, 32'h1);
    apb(1'b1, spis_pkg::ADDR_ENABLE, 32'hffff_ffff);
    expect_reg(spis_pkg::ADDR_ENABLE, 32'h1ff);
  endtask
  task automatic t_rx_under;
    expect_reg(RXD, 32'h0);
    irq_is(1'b1);
    apb(1'b1, spis_pkg::ADDR_ENABLE, 32'h0);
    irq_is(1'b0);
    expect_reg(STA, 32'h040);
    apb(1'b1, spis_pkg::ADDR_ENABLE, 32'h1ff);
    apb(1'b1, STA, 32'h1ff);
    irq_is(1'b0);
  endtask
  task automatic t_first_timeout;
    apb(1'b1, spis_pkg::ADDR_RX_THRESH, 32'h0);
    apb(1'b1, spis_pkg::ADDR_TIMEOUT, 32'h400);
    spi_master_model_i.xfer(8'ha5, mb);
    check({24'h0, mb}, 32'h0);
    expect_reg(STA, 32'h085);
    expect_reg(RXD, 32'ha5);
    apb(1'b1, STA, 32'h1ff);
    repeat (1100) @(posedge pclk);
    expect_reg(STA, 32'h100);
    apb(1'b1, STA, 32'h1ff);
    repeat (1100) @(posedge pclk);
    expect_reg(STA, 32'h0);
  endtask
  task automatic t_tx_drain;
    apb(1'b1, spis_pkg::ADDR_TIMEOUT, 32'hffff);
    apb(1'b1, spis_pkg::ADDR_RX_THRESH, 32'h2);
    apb(1'b1, spis_pkg::ADDR_TX_THRESH, 32'h2);
    apb(1'b1, TXD, 32'h3c);
    apb(1'b1, TXD, 32'hc3);
    apb(1'b1, STA, 32'h1ff);
    spi_master_model_i.xfer(8'h11, mb);
    check({24'h0, mb}, 32'h3c);
    expect_reg(STA, 32'h009);
    apb(1'b1, STA, 32'h1ff);
    spi_master_model_i.xfer(8'h22, mb);
    check({24'h0, mb}, 32'hc3);
    expect_reg(STA, 32'h002);
  endtask
  task automatic t_overflow;
    apb(1'b1, STA, 32'h1ff);
    for (int i = 3; i < 6; i++)
      spi_master_model_i.xfer(8'(i * 17), mb);
    expect_reg(STA, 32'h094);
    for (int i = 0; i < 5; i++)
      apb(1'b1, TXD, 32'(i));
    expect_reg(spis_pkg::ADDR_LEVELS, 32'h0004_0004);
    expect_reg(STA, 32'h0b4);
    for (int i = 1; i < 5; i++)
      expect_reg(RXD, 32'(i * 17));
  endtask
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_rx_under;
    t_first_timeout;
    t_tx_drain;
    t_overflow;
    print_verdict;
  end
  initial
  begin
    #100000;
    mismatches++;
    print_verdict;
  end
endmodule

// ==== verification/spis_props.sv ====
`timescale 1ns/10ps
module spis_props (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Register bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Link and interrupt
  input wire logic        spi_csn,
  input wire logic        spi_miso_oe,
  input wire logic        irq
);
  // A shadow of the enable register lets the interrupt be tied to its mask.
  logic [8:0] en_q;
  wire        acc   = psel && penable && pready;
  wire        en_wr = acc && pwrite && paddr == spis_pkg::ADDR_ENABLE;
  wire        rx_rd = acc && !pwrite && paddr == spis_pkg::ADDR_RX_DATA;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      en_q <= 9'h0;
    else if (en_wr)
      en_q <= pwdata[8:0];
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_irq_masked: assert property (irq |-> en_q != 9'h0)
    else $error("irq with all sources disabled");
  a_irq_off: assert property (en_wr && pwdata[8:0] == 9'h0 |=> !irq)
    else $error("irq stayed high after disable");
  a_under_irq: assert property (rx_rd && $rose(penable) && en_q[6] |=> irq)
    else $error("empty read raised no irq");
  a_under_zero: assert property (rx_rd && $rose(penable) |-> prdata == 32'h0)
    else $error("empty read returned data");
  a_err_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  a_status_width: assert property (psel && !pwrite && paddr == spis_pkg::ADDR_STATUS |-> prdata[31:9] == 23'h0)
    else $error("status shows bits above 8");
  a_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("more than one wait state");
  a_oe_on: assert property ($fell(spi_csn) |-> ##[1:4] spi_miso_oe)
    else $error("miso not driven after select");
  a_oe_off: assert property (spi_csn [*4] |-> !spi_miso_oe)
    else $error("miso driven while deselected");
endmodule
bind spi_slave_fifo_event_logic spis_props spis_props_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .spi_csn(spi_csn),
  .spi_miso_oe(spi_miso_oe), .irq(irq));
